// File: verilog/pcs_core.v
/*
  pcs_core: program counter, phase sequencer, return stack use,
  skip and branch dummy cycles, table reads and status flag capture.
  assumes the decoder presents op_code/op_target during t4 of the
  executing cycle and that program memory returns a word combinationally
  on mem_data for mem_addr.
*/
`timescale 1ns/100ps
`include "pcs_defs.vh"
module pcs_core (
  input wire clk, // system clock, 40 MHz
  input wire srst, // synchronous reset, active high
  input wire [2:0] op_code, // decoded operation of the executing instruction
  input wire [12:0] op_target, // jump or call target address
  input wire skip_met, // skip condition true for a skip operation
  input wire irq_pending, // enabled interrupt request is latched
  input wire [12:0] irq_vector, // interrupt entry address
  input wire pcl_wr, // software write to pc_low_byte
  input wire [7:0] pcl_wdata, // data for pc_low_byte
  input wire tdh_wr, // software write to table_data_high
  input wire [7:0] tdh_wdata, // data for table_data_high
  input wire tpl_wr, // software write to table_ptr_low
  input wire tph_wr, // software write to table_ptr_high
  input wire [7:0] tp_wdata, // data for either table pointer byte
  input wire alu_valid, // alu result ready this cycle
  input wire [3:0] alu_flags, // carry, aux carry, zero, overflow from the alu
  input wire [15:0] mem_data, // program memory word
  output wire [12:0] mem_addr, // program memory address
  output reg [15:0] instr, // fetched instruction word
  output reg instr_valid, // instr is real, not a dummy
  output wire [1:0] phase, // current phase phase_clocks
  output wire [7:0] pc_low_byte, // readable low counter byte
  output reg [7:0] table_data_high, // high byte of last table read
  output reg [7:0] tbl_low_data, // low byte of last table read
  output reg tbl_low_valid, // pulse: tbl_low_data to be written to target
  output reg irq_ack, // pulse: interrupt acknowledged
  output reg [3:0] status_flags, // status register flag field
  output wire stack_full // return stack full
);
  reg [12:0] pc;
  reg [1:0] ph;
  reg dummy;
  reg tbl_busy;
  reg tbl_last;
  reg [7:0] table_ptr_low;
  reg [7:0] table_ptr_high;
  reg [12:0] next_pc;
  reg next_dummy;
  reg push;
  reg pop;
  wire [12:0] top_addr;
  wire stk_empty;
  wire t4;
  wire [12:0] tbl_addr;
  wire take_irq;
  wire start_tbl;
  //////////////////////////////////////////////////////////////////////////////
  // return stack, invisible to software
  pcs_stack u_stack (
    .clk(clk),
    .srst(srst),
    .push(push),
    .pop(pop),
    .push_addr(pc),
    .top_addr(top_addr),
    .full(stack_full),
    .empty(stk_empty)
  );
  //////////////////////////////////////////////////////////////////////////////
  // phase sequencer: one pass of four phases is an instruction cycle
  always @(posedge clk)
  begin
    if (srst)
    begin
      ph <= `PCS_PHASE_T1;
    end
    else
    begin
      ph <= ph + 2'h1;
    end
  end
  assign phase = ph;
  assign t4 = (ph == `PCS_PHASE_T4);
  //////////////////////////////////////////////////////////////////////////////
  // table address: pointer high supplies the upper five bits, PCS_LAST_PAGE when tbl_last is set
  assign tbl_addr = tbl_last ? {`PCS_LAST_PAGE, table_ptr_low}
                             : {table_ptr_high[4:0], table_ptr_low};
  // memory serves fetches unless a table read owns the second cycle
  assign mem_addr = tbl_busy ? tbl_addr : pc;
  assign pc_low_byte = pc[7:0];
  //////////////////////////////////////////////////////////////////////////////
  // both table read codes share one decode, used by the start logic
  function is_table_op;
    input [2:0] code;
    begin
      is_table_op = (code == `PCS_OP_TBLRD) || (code == `PCS_OP_TBLRD_LAST);
    end
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // interrupt entry: only at t4 of a real cycle with no low byte write.
  // a full stack holds the request back; the requester keeps it pending,
  // so it is served at the first real cycle after a return frees a level.
  assign take_irq = t4 && !tbl_busy && !pcl_wr && irq_pending && !stack_full && !dummy;
  // table read starts only from a real instruction, never from a dummy slot
  assign start_tbl = t4 && !tbl_busy && !pcl_wr && !dummy && is_table_op(op_code);
  //////////////////////////////////////////////////////////////////////////////
  // next counter value, decided at the end of each instruction cycle
  always @*
  begin
    next_pc = pc + 13'h1;
    next_dummy = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    if (t4 && !tbl_busy)
    begin
      if (pcl_wr)
      begin
        next_pc = {pc[12:8], pcl_wdata};
        next_dummy = 1'b1;
      end
      else if (take_irq)
      begin
        next_pc = irq_vector;
        next_dummy = 1'b1;
        push = 1'b1;
      end
      // a dummy cycle executes nothing, whatever the decoder shows
      else if (!dummy)
      begin
        case (op_code)
          `PCS_OP_JUMP:
          begin
            next_pc = op_target;
            next_dummy = 1'b1;
          end
          `PCS_OP_CALL:
          begin
            next_pc = op_target;
            next_dummy = 1'b1;
            push = 1'b1;
          end
          `PCS_OP_RET, `PCS_OP_RETURN_FROM_INTERRUPT:
          begin
            next_pc = top_addr;
            next_dummy = 1'b1;
            pop = !stk_empty;
          end
          `PCS_OP_SKIP:
          begin
            if (skip_met)
            begin
              next_dummy = 1'b1;
            end
          end
          default:
          begin
            next_dummy = 1'b0;
          end
        endcase
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // counter steps at the start of t1, the fetch phase
  always @(posedge clk)
  begin
    if (srst)
    begin
      pc <= `PCS_RESET_VECTOR;
      dummy <= 1'b1;
      irq_ack <= 1'b0;
      instr <= 16'h0000;
      instr_valid <= 1'b0;
    end
    else
    begin
      // acknowledge pulses on the edge that loads the vector
      irq_ack <= take_irq;
      if (t4 && !tbl_busy)
      begin
        pc <= next_pc;
        dummy <= next_dummy;
        instr <= mem_data;
        // the word fetched now is discarded when the next cycle is a dummy
        instr_valid <= !next_dummy;
      end
      else if (t4)
      begin
        instr_valid <= 1'b0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // table read: second instruction cycle reads the pointed word
  always @(posedge clk)
  begin
    if (srst)
    begin
      tbl_busy <= 1'b0;
      tbl_last <= 1'b0;
      table_data_high <= `PCS_TBL_RESET;
      tbl_low_data <= `PCS_TBL_RESET;
      tbl_low_valid <= 1'b0;
    end
    else
    begin
      tbl_low_valid <= 1'b0;
      // software save and restore of the high byte; a completing read wins
      if (tdh_wr)
      begin
        table_data_high <= tdh_wdata;
      end
      if (t4 && tbl_busy)
      begin
        tbl_busy <= 1'b0;
        tbl_low_data <= mem_data[7:0];
        table_data_high <= mem_data[15:8];
        tbl_low_valid <= 1'b1;
      end
      else if (start_tbl)
      begin
        tbl_busy <= 1'b1;
        tbl_last <= (op_code == `PCS_OP_TBLRD_LAST);
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // table pointer bytes, software written
  always @(posedge clk)
  begin
    if (srst)
    begin
      table_ptr_low <= `PCS_TBL_RESET;
      table_ptr_high <= `PCS_TBL_RESET;
    end
    else
    begin
      if (tpl_wr)
      begin
        table_ptr_low <= tp_wdata;
      end
      if (tph_wr)
      begin
        table_ptr_high <= tp_wdata;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // status flags follow each alu result
  always @(posedge clk)
  begin
    if (srst)
    begin
      status_flags <= 4'h0;
    end
    else if (alu_valid)
    begin
      status_flags <= alu_flags;
    end
  end
endmodule // pcs_core

// File: verilog/pcs_defs.vh
/*
  constants for the program counter, return stack and table read core.
  assumes a 13-bit program space of 16-bit words and an 8-level stack.
*/
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH
`define PCS_PC_W 13
`define PCS_PAGE_W 8
`define PCS_HI_W 5
`define PCS_WORD_W 16
`define PCS_DEPTH 8
`define PCS_SP_W 3
`define PCS_RESET_VECTOR 13'h0000
`define PCS_SP_RESET 3'h0
`define PCS_TBL_RESET 8'h00
`define PCS_PHASE_W 2
`define PCS_PHASE_T1 2'h0
`define PCS_PHASE_T4 2'h3
`define PCS_OP_W 3
`define PCS_OP_NONE 3'h0
`define PCS_OP_JUMP 3'h1
`define PCS_OP_CALL 3'h2
`define PCS_OP_RET 3'h3
`define PCS_OP_RETURN_FROM_INTERRUPT 3'h4
`define PCS_OP_SKIP 3'h5
`define PCS_OP_TBLRD 3'h6
`define PCS_OP_TBLRD_LAST 3'h7
`define PCS_LAST_PAGE 5'h1f
`endif

// File: verilog/pcs_stack.v
/*
  pcs_stack: 8-level return address stack of program counter values.
  assumes the parent never pushes and pops in the same cycle.
*/
`timescale 1ns/100ps
`include "pcs_defs.vh"
module pcs_stack (
  input wire clk, // system clock
  input wire srst, // synchronous reset, active high
  input wire push, // store push_addr on top
  input wire pop, // remove top entry
  input wire [12:0] push_addr, // address to save
  output wire [12:0] top_addr, // most recently saved address
  output reg full, // all levels hold an address
  output reg empty // no level holds an address
);
  reg [12:0] level [0:`PCS_DEPTH-1];
  reg [2:0] sp;
  reg [3:0] count;
  //////////////////////////////////////////////////////////////////////////////
  // top entry sits just below the write pointer
  assign top_addr = level[sp - 3'h1];
  //////////////////////////////////////////////////////////////////////////////
  // circular storage: a push when full overwrites the oldest entry
  always @(posedge clk)
  begin
    if (push)
    begin
      level[sp] <= push_addr;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // pointer and occupancy; reset leaves the stack empty
  always @(posedge clk)
  begin
    if (srst)
    begin
      sp <= `PCS_SP_RESET;
      count <= 4'h0;
      full <= 1'b0;
      empty <= 1'b1;
    end
    else if (push)
    begin
      sp <= sp + 3'h1;
      if (count != 4'h8)
      begin
        count <= count + 4'h1;
      end
      full <= (count >= 4'h7);
      empty <= 1'b0;
    end
    else if (pop && count != 4'h0)
    begin
      sp <= sp - 3'h1;
      count <= count - 4'h1;
      full <= 1'b0;
      empty <= (count == 4'h1);
    end
  end
endmodule // pcs_stack

// File: tb/pcs_prog_mem.sv
/*
  pcs_prog_mem: program memory model, 8k words of 16 bits.
  assumes a combinational read on the address from pcs_core.
*/
`timescale 1ns/100ps
module pcs_prog_mem (
  input wire [12:0] mem_addr, // word address
  output wire [15:0] mem_data // word at mem_addr
);
  // fixed pattern of the address, so that every word can be predicted
  function [15:0] word(input [12:0] a);
    word = {a[7:0] ^ 8'h3c, 3'h0, a[12:8]};
  endfunction
  // every address of the 8k space decoded, no wait
  assign mem_data = word(mem_addr);
endmodule // pcs_prog_mem

// File: tb/pcs_core_asserts.sv
/*
  pcs_core_asserts: port checker for pcs_core.
  assumes one clock domain and the active-high synchronous srst.
*/
`timescale 1ns/100ps
module pcs_core_asserts (
  input wire clk, // system clock
  input wire srst, // synchronous reset
  input wire alu_valid, // alu result strobe
  input wire [3:0] alu_flags, // alu flags
  input wire [12:0] irq_vector, // interrupt entry
  input wire [15:0] mem_data, // program word
  input wire [12:0] mem_addr, // program address
  input wire [1:0] phase, // phase counter
  input wire [7:0] pc_low_byte, // counter low byte
  input wire [7:0] table_data_high, // table high byte
  input wire [7:0] tbl_low_data, // table low byte
  input wire tbl_low_valid, // table low byte strobe
  input wire irq_ack, // interrupt acknowledge
  input wire [3:0] status_flags, // status flags
  input wire stack_full // stack full
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////
  a_phase_steps: assert property (1'b1 |=> phase == $past(phase) + 2'h1)
    else $error("phase did not advance by one");
  a_pc_held: assert property (phase != 2'h3 |=> $stable(pc_low_byte))
    else $error("counter changed outside t4");
  a_tbl_slot: assert property (tbl_low_valid |-> phase == 2'h0)
    else $error("table byte not at a cycle boundary");
  a_tbl_pair: assert property (tbl_low_valid |-> {table_data_high, tbl_low_data} == $past(mem_data))
    else $error("table bytes differ from word");
  a_full_holds: assert property (stack_full |=> !irq_ack)
    else $error("interrupt acknowledged on full stack");
  a_ack_vector: assert property (irq_ack |-> mem_addr == $past(irq_vector))
    else $error("interrupt did not load vector");
  a_reset_vector: assert property ($fell(srst) |-> mem_addr == 13'h0000 && !stack_full)
    else $error("reset state wrong");
  a_flags_load: assert property (alu_valid |=> status_flags == $past(alu_flags))
    else $error("status flags not captured");
  // main scenarios reached
  c_ack: cover property (irq_ack);
  c_tbl: cover property (tbl_low_valid);
  c_full: cover property (stack_full);
endmodule // pcs_core_asserts
bind pcs_core pcs_core_asserts i_chk (.clk(clk), .srst(srst), .alu_valid(alu_valid),
  .alu_flags(alu_flags), .irq_vector(irq_vector), .mem_data(mem_data), .mem_addr(mem_addr),
  .phase(phase), .pc_low_byte(pc_low_byte), .table_data_high(table_data_high),
  .tbl_low_data(tbl_low_data), .tbl_low_valid(tbl_low_valid), .irq_ack(irq_ack),
  .status_flags(status_flags), .stack_full(stack_full));

// File: tb/pcs_core_bench.sv
/*
  pcs_core_bench: sequencing, stack and table read tests of pcs_core.
  assumes pcs_prog_mem as memory and the checker bound to pcs_core.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin n_fail = n_fail + 1; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module pcs_core_bench;
  reg clk = 0, srst = 1, skip_met = 0, irq_pending = 0, pcl_wr = 0, tdh_wr = 0;
  reg tpl_wr = 0, tph_wr = 0, alu_valid = 0;
  reg [2:0] op_code = 0;
  reg [12:0] op_target = 0, pc = 0, ta = 0, irq_vector = 13'h0123;
  reg [12:0] sv[$];
  reg [7:0] pcl_wdata = 0, tdh_wdata = 0, tp_wdata = 0;
  reg [3:0] alu_flags = 0, flg = 0;
  reg [15:0] r = 16'd7566;
  integer checks = 0, n_fail = 0, i, k;
  wire [12:0] mem_addr;
  wire [15:0] mem_data, instr;
  wire [1:0] phase;
  wire [7:0] pc_low_byte, table_data_high, tbl_low_data;
  wire [3:0] status_flags;
  wire instr_valid, tbl_low_valid, irq_ack, stack_full;
  ////////////////////////////////////////////////////////////////////////
  pcs_core i_dut (.clk(clk), .srst(srst), .op_code(op_code), .op_target(op_target),
    .skip_met(skip_met), .irq_pending(irq_pending), .irq_vector(irq_vector),
    .pcl_wr(pcl_wr), .pcl_wdata(pcl_wdata), .tdh_wr(tdh_wr), .tdh_wdata(tdh_wdata),
    .tpl_wr(tpl_wr), .tph_wr(tph_wr), .tp_wdata(tp_wdata), .alu_valid(alu_valid),
    .alu_flags(alu_flags), .mem_data(mem_data), .mem_addr(mem_addr), .instr(instr),
    .instr_valid(instr_valid), .phase(phase), .pc_low_byte(pc_low_byte),
    .table_data_high(table_data_high), .tbl_low_data(tbl_low_data),
    .tbl_low_valid(tbl_low_valid), .irq_ack(irq_ack), .status_flags(status_flags),
    .stack_full(stack_full));
  pcs_prog_mem i_mem (.mem_addr(mem_addr), .mem_data(mem_data));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // go to the next edge that ends t4, bounded
  task step;
    begin
      k = 0;
      @(posedge clk);
      while (phase !== 2'h3 && k < 8)
      begin
        @(posedge clk);
        k = k + 1;
      end
      if (k == 8)
      begin
        n_fail = n_fail + 1;
        report_and_stop;
      end
    end
  endtask
  // one instruction cycle carrying op; f[0] writes the low byte, f[1] is the skip result
  task run(input [2:0] op, input [12:0] tgt, input [1:0] f);
    begin
      step;
      op_code <= op;
      op_target <= tgt;
      pcl_wr <= f[0];
      skip_met <= f[1];
      pcl_wdata <= r[7:0];
      r = lfsr(r);
      alu_valid <= r[0];
      alu_flags <= r[4:1];
      if (r[0])
        flg = r[4:1];
      #1 pc = mem_addr;
      step;
      op_code <= 3'h0;
      pcl_wr <= 1'b0;
      @(negedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    `CHK(mem_addr, 13'h0000)
    `CHK(stack_full, 1'b0)
    $display("reset test done");
    for (i = 0; i < 6; i = i + 1)
    begin
      run(3'h0, 13'h0, 2'b00);
      `CHK(mem_addr, pc + 13'h1)
      `CHK(pc_low_byte, mem_addr[7:0])
      `CHK(instr, i_mem.word(pc))
      `CHK(instr_valid, 1'b1)
      `CHK(status_flags, flg)
      run(3'h1, r[12:0], 2'b00);
      `CHK(mem_addr, op_target)
      `CHK(instr_valid, 1'b0)
      run(3'h5, 13'h0, {r[3], 1'b0});
      `CHK(mem_addr, pc + 13'h1)
      `CHK(instr_valid, ~skip_met)
      run(3'h0, 13'h0, 2'b01);
      `CHK(mem_addr, {pc[12:8], pcl_wdata})
      `CHK(instr_valid, 1'b0)
      ta = i[0] ? {5'h1f, r[7:0]} : r[12:0];
      @(posedge clk);
      tpl_wr <= 1'b1;
      tp_wdata <= r[7:0];
      @(posedge clk);
      tpl_wr <= 1'b0;
      tph_wr <= 1'b1;
      tp_wdata <= r[15:8];
      @(posedge clk);
      tph_wr <= 1'b0;
      run({2'b11, i[0]}, 13'h0, 2'b00);
      `CHK(mem_addr, ta)
      step;
      @(negedge clk);
      `CHK(tbl_low_valid, 1'b1)
      `CHK({table_data_high, tbl_low_data}, i_mem.word(ta))
      @(posedge clk);
      tdh_wr <= 1'b1;
      tdh_wdata <= ~r[7:0];
      @(posedge clk);
      tdh_wr <= 1'b0;
      @(negedge clk);
      `CHK(table_data_high, tdh_wdata)
    end
    $display("sequencing and table test done");
    for (i = 0; i < 17; i = i + 1)
      if (i < 9)
      begin
        run(3'h2, r[12:0], 2'b00);
        sv.push_back(pc);
        if (sv.size() > 8)
          void'(sv.pop_front());
        `CHK(mem_addr, op_target)
        if (i == 7)
          `CHK(stack_full, 1'b1)
      end
      else
      begin
        run(3'h3, 13'h0, 2'b00);
        ta = sv.pop_back();
        `CHK(mem_addr, ta)
      end
    $display("stack test done");
    for (i = 0; i < 8; i = i + 1)
    begin
      run(3'h2, r[12:0], 2'b00);
      sv.push_back(pc);
    end
    @(posedge clk);
    irq_pending <= 1'b1;
    run(3'h0, 13'h0, 2'b00);
    run(3'h0, 13'h0, 2'b00);
    run(3'h3, 13'h0, 2'b00);
    ta = sv.pop_back();
    `CHK(mem_addr, ta)
    ta = ta + 13'h1;
    k = 0;
    while (irq_ack !== 1'b1 && k < 16)
    begin
      @(posedge clk);
      k = k + 1;
    end
    `CHK(irq_ack, 1'b1)
    `CHK(mem_addr, irq_vector)
    irq_pending <= 1'b0;
    run(3'h4, 13'h0, 2'b00);
    `CHK(mem_addr, ta)
    $display("interrupt test done");
    report_and_stop;
  end
endmodule // pcs_core_bench
